// ==== cmtc_map.svh ====
// Register offsets, field positions, reset values and divider settings
// of the compare-match timer channel.
// Assumes a 32-bit classic Wishbone bus, one register per aligned word.
`ifndef CMTC_MAP_SVH
`define CMTC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CMTC_OFS_START 8'h00
`define CMTC_OFS_CTRL 8'h04
`define CMTC_OFS_COUNT 8'h08
`define CMTC_OFS_PERIOD 8'h0c
`define CMTC_OFS_EVT 8'h10
`define CMTC_OFS_MASK 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CMTC_RUN_BIT 0
`define CMTC_FLAG_BIT 7
`define CMTC_IE_BIT 6
`define CMTC_CKS_HI 1
`define CMTC_CKS_LO 0
`define CMTC_EVT_MATCH 0
`define CMTC_EVT_WRAP 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CMTC_RST_PERIOD 16'hffff
`define CMTC_RST_COUNT 16'h0000
`define CMTC_RST_CKS 2'h0
`define CMTC_RST_MASK 2'h0

// ----------------------------------------------------------------------
// Divider: log2 of the peripheral clock divide ratio per select code
// ----------------------------------------------------------------------
`define CMTC_DIV_EXP_0 3
`define CMTC_DIV_EXP_1 5
`define CMTC_DIV_EXP_2 7
`define CMTC_DIV_EXP_3 9
`define CMTC_PRE_W 10

`endif

// ==== cmtc_pkg.sv ====
// Types shared by the compare-match timer channel files.
// Assumes cmtc_map.svh on the include path.
package cmtc_pkg;

    // Bus handshake states
    typedef enum logic [0:0] {
        CMTC_BUS_IDLE = 1'b0,
        CMTC_BUS_ACK = 1'b1
    } cmtc_bus_st_t;

    // Counter clock select codes
    typedef enum logic [1:0] {
        CMTC_DIV8 = 2'b00,
        CMTC_DIV32 = 2'b01,
        CMTC_DIV128 = 2'b10,
        CMTC_DIV512 = 2'b11
    } cmtc_cks_t;

    // Wishbone request as one carrier
    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } cmtc_wb_req_t;

    // Control/status word fields
    typedef struct packed {
        logic match_flag;
        logic match_irq_enable;
        cmtc_cks_t clk_sel;
    } cmtc_ctrl_t;

endpackage

// ==== cmtc_prescaler.sv ====
// Peripheral clock divider for the compare-match timer channel.
// Assumes one clock; emits a one-cycle count enable at the chosen rate.
`include "cmtc_map.svh"

module cmtc_prescaler
    import cmtc_pkg::*;
#(
    parameter int PRE_W = `CMTC_PRE_W
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire cmtc_cks_t cks_i,
    // Count enable
    output logic tick_o
);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    if (PRE_W < `CMTC_DIV_EXP_3)
    begin : g_bad_w
        $error("cmtc_prescaler: PRE_W too small for largest ratio");
    end

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    function automatic logic div_hit(logic [PRE_W-1:0] c, cmtc_cks_t s);
        int e;
        logic hit;
        case (s)
            CMTC_DIV8: e = `CMTC_DIV_EXP_0;
            CMTC_DIV32: e = `CMTC_DIV_EXP_1;
            CMTC_DIV128: e = `CMTC_DIV_EXP_2;
            default: e = `CMTC_DIV_EXP_3;
        endcase
        hit = 1'b1;
        for (int i = 0; i < PRE_W; i++)
        begin
            if (i < e && !c[i])
            begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    logic tick_q;
    logic tick_d;

    // Held at zero while stopped so the first period is always whole
    always_comb
    begin
        pre_d = '0;
        tick_d = 1'b0;
        if (run_i)
        begin
            pre_d = pre_q + 1'b1;
            tick_d = div_hit(pre_q, cks_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            pre_q <= pre_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule // cmtc_prescaler

// ==== cmtc_timer.sv ====
// Compare-match timer channel with classic Wishbone register slave.
// Assumes one 20 MHz clock, synchronous active-high reset, and a
// single-cycle classic Wishbone master on a 32-bit bus.
`include "cmtc_map.svh"

module cmtc_timer
    import cmtc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad_cnt
        $error("cmtc_timer: CNT_W must be 2 to 16");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge of a 16-bit register from the low two lanes
    function automatic logic [15:0] lane_merge(
        logic [15:0] old,
        logic [31:0] dat,
        logic [3:0] sel
    );
        logic [15:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    function automatic logic [31:0] zext16(logic [15:0] v);
        return {16'h0000, v};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cmtc_wb_req_t req;
    cmtc_bus_st_t bus_q;
    cmtc_bus_st_t bus_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic run_q;
    logic run_d;
    cmtc_ctrl_t ctl_q;
    cmtc_ctrl_t ctl_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] per_q;
    logic [CNT_W-1:0] per_d;
    logic [1:0] evt_q;
    logic [1:0] evt_d;
    logic [1:0] msk_q;
    logic [1:0] msk_d;
    logic irq_q;
    logic irq_d;
    logic tick;
    logic wr_fire;
    logic rd_fire;
    logic hit;
    logic wrap;
    logic [15:0] ctl_word;
    logic [15:0] cnt_w;
    logic [15:0] per_w;

    // One driver for the whole carrier, fields in struct order
    assign req = {
        wb_adr_i, wb_we_i,
        wb_sel_i, wb_dat_i};

    assign cnt_w = 16'(cnt_q);
    assign per_w = 16'(per_q);
    assign ctl_word = {8'h00, ctl_q.match_flag, ctl_q.match_irq_enable,
        4'h0, ctl_q.clk_sel};

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    cmtc_prescaler #(
        .PRE_W(`CMTC_PRE_W)
    ) u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_q),
        .cks_i(ctl_q.clk_sel),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Writes and read side effects land on the edge the master sees ack
    assign wr_fire = wb_cyc_i && wb_stb_i && bus_q == CMTC_BUS_ACK
        && req.we;
    assign rd_fire = wb_cyc_i && wb_stb_i && bus_q == CMTC_BUS_ACK
        && !req.we;

    always_comb
    begin
        bus_d = CMTC_BUS_IDLE;
        dat_d = dat_q;
        case (bus_q)
            CMTC_BUS_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    bus_d = CMTC_BUS_ACK;
                    dat_d = 32'h0000_0000;
                    if (!req.we)
                    begin
                        case (req.adr)
                            `CMTC_OFS_START:
                                dat_d = {31'h0000_0000, run_q};
                            `CMTC_OFS_CTRL: dat_d = zext16(ctl_word);
                            `CMTC_OFS_COUNT: dat_d = zext16(cnt_w);
                            `CMTC_OFS_PERIOD: dat_d = zext16(per_w);
                            `CMTC_OFS_EVT: dat_d = {30'h0000_0000, evt_q};
                            `CMTC_OFS_MASK: dat_d = {30'h0000_0000, msk_q};
                            default: dat_d = 32'h0000_0000;
                        endcase
                    end
                end
            end
            CMTC_BUS_ACK:
            begin
                // Ack lasts one cycle; the master must drop stb after it
                bus_d = CMTC_BUS_IDLE;
            end
            default:
            begin
                bus_d = CMTC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_q <= CMTC_BUS_IDLE;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            bus_q <= bus_d;
            dat_q <= dat_d;
        end
    end

    // ------------------------------------------------------------------
    // Timer core and registers
    // ------------------------------------------------------------------
    assign hit = tick && (cnt_q == per_q);
    assign wrap = tick && (cnt_q == {CNT_W{1'b1}}) && !hit;

    always_comb
    begin
        logic [15:0] tmp;
        tmp = 16'h0000;
        run_d = run_q;
        ctl_d = ctl_q;
        cnt_d = cnt_q;
        per_d = per_q;
        evt_d = evt_q;
        msk_d = msk_q;

        // Counting
        if (tick)
        begin
            if (hit)
            begin
                cnt_d = '0;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end

        // Software writes
        if (wr_fire)
        begin
            case (req.adr)
                `CMTC_OFS_START:
                begin
                    if (req.sel[0])
                    begin
                        run_d = req.dat[`CMTC_RUN_BIT];
                    end
                end
                `CMTC_OFS_CTRL:
                begin
                    if (req.sel[0])
                    begin
                        ctl_d.match_irq_enable = req.dat[`CMTC_IE_BIT];
                        ctl_d.clk_sel =
                            cmtc_cks_t'(req.dat[`CMTC_CKS_HI:`CMTC_CKS_LO]);
                        if (!req.dat[`CMTC_FLAG_BIT])
                        begin
                            ctl_d.match_flag = 1'b0;
                        end
                    end
                end
                `CMTC_OFS_COUNT:
                begin
                    // Software load beats a coincident count edge
                    tmp = lane_merge(cnt_w, req.dat, req.sel);
                    cnt_d = tmp[CNT_W-1:0];
                end
                `CMTC_OFS_PERIOD:
                begin
                    tmp = lane_merge(per_w, req.dat, req.sel);
                    per_d = tmp[CNT_W-1:0];
                end
                `CMTC_OFS_MASK:
                begin
                    if (req.sel[0])
                    begin
                        msk_d = req.dat[1:0];
                    end
                end
                default:
                begin
                    run_d = run_d;
                end
            endcase
        end

        // Clear only what the read reported; a later event survives
        if (rd_fire && req.adr == `CMTC_OFS_EVT)
        begin
            evt_d = evt_q & ~dat_q[1:0];
        end

        // Hardware sets win over any clear in the same cycle
        if (hit)
        begin
            ctl_d.match_flag = 1'b1;
            evt_d[`CMTC_EVT_MATCH] = 1'b1;
        end
        if (wrap)
        begin
            evt_d[`CMTC_EVT_WRAP] = 1'b1;
        end

        irq_d = (ctl_d.match_flag && ctl_d.match_irq_enable)
            || (|(evt_d & msk_d));
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_q <= 1'b0;
            ctl_q <= '{1'b0, 1'b0, CMTC_DIV8};
            cnt_q <= CNT_W'(`CMTC_RST_COUNT);
            per_q <= CNT_W'(`CMTC_RST_PERIOD);
            evt_q <= 2'b00;
            msk_q <= `CMTC_RST_MASK;
            irq_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            ctl_q <= ctl_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            evt_q <= evt_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o = (bus_q == CMTC_BUS_ACK);
    assign wb_dat_o = dat_q;
    assign irq_o = irq_q;

endmodule // cmtc_timer

// ==== cmtc_timer_asserts.sv ====
// Port-level checks for the compare-match timer channel.
// Assumes a classic Wishbone master that drops stb after each ack.
module cmtc_timer_asserts
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus and interrupt
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // Own disable: the antecedent is the reset itself
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !wb_ack_o && !irq_o) else $error("outputs live in reset");
    unmapped_rd_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        !wb_we_i && wb_adr_i > 8'h14 |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (wb_ack_o && !wb_we_i
        |-> wb_dat_o[31:16] == 16'h0000) else $error("upper lanes not zero");
    dat_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    irq_sticky_a: assert property ($fell(irq_o) |-> $past(wb_ack_o) ||
        $past(wb_ack_o, 2) || $past(rst_i, 2)) else $error("irq dropped alone");

    cover property ($rose(irq_o));
    cover property (wb_ack_o && wb_we_i);
    cover property (wb_ack_o && !wb_we_i && wb_dat_o[7]);
endmodule // cmtc_timer_asserts

bind cmtc_timer cmtc_timer_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

// ==== tb_top.sv ====
// Self-checking bench for the compare-match timer channel.
// Assumes cmtc_pkg compiled first and the checker bound to the dut.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'b0011;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o;
    logic [31:0] exp_q[$];
    logic [1:0] cs;
    logic [15:0] p;
    int failures = 0, cmp_count = 0, n, lo;

    cmtc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o));

    always #25 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask

    // One classic cycle; reads leave their expectation in the queue
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] e);
        int k;
        @(posedge clk_i);
        if (!w)
            exp_q.push_back(e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        // Waits as long as it takes; only the watchdog ends a hang
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1);
        chk("ack_wait", 32'd2, 32'(k));
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic conclude();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        if (!rst_i && wb_ack_o === 1'b1 && wb_we_i === 1'b0 &&
            exp_q.size() > 0)
            chk("rdata", exp_q.pop_front(), wb_dat_o);
    end

    initial
    begin
        repeat (40000) @(posedge clk_i);
        failures++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(14883));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 8'h00, 0, 32'h0000_0000);
        wb(0, 8'h04, 0, 32'h0000_0000);
        wb(0, 8'h08, 0, 32'h0000_0000);
        wb(0, 8'h0c, 0, 32'h0000_ffff);
        wb(0, 8'h18, 0, 32'h0000_0000);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++)
        begin
            cs = 2'(i);
            p = 16'($urandom_range(3, 1));
            wb(1, 8'h0c, {16'h0000, p}, 0);
            wb(1, 8'h04, 32'h0000_0040 | 32'(cs), 0);
            wb(1, 8'h08, 32'h0000_0000, 0);
            wb(1, 8'h00, 32'h0000_0001, 0);
            n = 0;
            while (irq_o !== 1'b1 && n < 5000)
            begin
                @(posedge clk_i);
                n++;
            end
            // First tick a clock late, irq a clock after the match
            lo = (int'(p) + 1) << (3 + 2 * i);
            chk("match_time", lo + 2, n);
            wb(1, 8'h00, 32'h0000_0000, 0);
            wb(0, 8'h08, 0, 32'h0000_0000);
            wb(0, 8'h04, 0, 32'h0000_00c0 | 32'(cs));
            wb(1, 8'h04, 32'h0000_00c0 | 32'(cs), 0);
            wb(0, 8'h04, 0, 32'h0000_00c0 | 32'(cs));
            wb(1, 8'h04, 32'h0000_0040 | 32'(cs), 0);
            // A one written to a clear flag must not set it
            wb(1, 8'h04, 32'h0000_00c0 | 32'(cs), 0);
            wb(0, 8'h04, 0, 32'h0000_0040 | 32'(cs));
            wb(0, 8'h10, 0, 32'h0000_0001);
            wb(0, 8'h10, 0, 32'h0000_0000);
            repeat (2) @(posedge clk_i);
            chk("irq_clear", 32'h0, {31'h0, irq_o});
        end
        $display("test match_per_divider done");
        // Wrap two ticks after start, match three ticks later
        wb(1, 8'h04, 32'h0000_0000, 0);
        wb(1, 8'h0c, 32'h0000_0002, 0);
        wb(1, 8'h08, 32'h0000_fffe, 0);
        wb(1, 8'h14, 32'h0000_0003, 0);
        wb(1, 8'h00, 32'h0000_0001, 0);
        n = 0;
        while (irq_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("wrap_time", 32'd18, 32'(n));
        wb(1, 8'h00, 32'h0000_0000, 0);
        wb(0, 8'h10, 0, 32'h0000_0002);
        wb(1, 8'h14, 32'h0000_0002, 0);
        wb(1, 8'h00, 32'h0000_0001, 0);
        repeat (28) @(posedge clk_i);
        chk("irq_disabled", 32'h0, {31'h0, irq_o});
        wb(1, 8'h00, 32'h0000_0000, 0);
        wb(0, 8'h04, 0, 32'h0000_0080);
        // Nonzero value so a stopped counter that still moves shows up
        wb(1, 8'h08, 32'h0000_0005, 0);
        repeat (50) @(posedge clk_i);
        wb(0, 8'h08, 0, 32'h0000_0005);
        wb(1, 8'h14, 32'h0000_0001, 0);
        repeat (3) @(posedge clk_i);
        chk("irq_masked_on", 32'h1, {31'h0, irq_o});
        wb(0, 8'h10, 0, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        chk("irq_read_clear", 32'h0, {31'h0, irq_o});
        $display("test wrap_and_mask done");
        conclude();
    end
endmodule // tb_top
